// ---- hdl/awc_pkg.sv ----
// Package for the converter window comparator: offsets, resets, channels
package awc_pkg;
  // Special-function register addresses
  localparam logic [7:0] ADDR_RESULT_LOW   = 8'hbd;
  localparam logic [7:0] ADDR_RESULT_HIGH  = 8'hbe;
  localparam logic [7:0] ADDR_INPUT_SELECT = 8'hbb;
  localparam logic [7:0] ADDR_GT_LOW       = 8'hc3;
  localparam logic [7:0] ADDR_GT_HIGH      = 8'hc4;
  localparam logic [7:0] ADDR_LT_LOW       = 8'hc5;
  localparam logic [7:0] ADDR_LT_HIGH      = 8'hc6;
  localparam logic [7:0] ADDR_STATUS       = 8'hc7;
  // Values after reset
  localparam logic [15:0] GT_RESET         = 16'hffff;
  localparam logic [15:0] LT_RESET         = 16'h0000;
  localparam logic [4:0]  SELECT_RESET     = 5'h1f;
  // Status field position
  localparam int          FLAG_BIT         = 0;
  // Special channel codes of the input selector
  localparam logic [4:0] CH_LAST_PIN       = 5'h16;
  localparam logic [4:0] CH_TEMP           = 5'h1b;
  localparam logic [4:0] CH_BATTERY        = 5'h1c;
  localparam logic [4:0] CH_CORE_SUPPLY    = 5'h1d;
  localparam logic [4:0] CH_MAIN_SUPPLY    = 5'h1e;
  localparam logic [4:0] CH_GROUND         = 5'h1f;
  // Source kinds on the routing output
  typedef enum logic [5:0] {
    AWC_SRC_PIN      = 6'h01,
    AWC_SRC_TEMP     = 6'h02,
    AWC_SRC_BATTERY  = 6'h04,
    AWC_SRC_CORE     = 6'h08,
    AWC_SRC_MAIN     = 6'h10,
    AWC_SRC_GROUND   = 6'h20
  } awc_src_t;
endpackage : awc_pkg

// ---- hdl/awc_window_compare.sv ----
// Converter window comparator with limit registers and input selector
// Contract
// R1: Compare every result against both limits
// R2: Flag drives interrupt and reads as status
// R3: Limits come only from the two pairs
// R4: Limit ordering alone picks inside or outside
// R5: Greater limit bytes at 0xc4 and 0xc3
// R6: Less limit bytes at 0xc6 and 0xc5
// R7: Software zeroes low limit bytes in 8-bit
// R8: Inside: above greater and below less
// R9: Outside: below lower or above upper bound
// R10: Single-ended result is 10-bit unsigned
// R11: Compare the word exactly as justified
// R12: Route one positive source to converter
// R13: Select register picks the positive channel
// R14: Software sets pins used as analog inputs
// R15: Software makes crossbar skip analog pins
// R16: Evaluate on each result, hold until cleared
`timescale 1ns/1ps
module awc_window_compare #(
  parameter int PIN_COUNT = 23
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic                  sfr_rd_i,
  input  wire logic [7:0]            sfr_wdata_i,
  output logic      [7:0]            sfr_rdata_o,
  input  wire logic                  result_valid_i,
  input  wire logic [15:0]           result_word_i,
  input  wire logic                  flag_clear_i,
  output logic                       window_hit_flag_o,
  output logic                       window_irq_o,
  output logic [4:0]                 input_select_o,
  output logic [PIN_COUNT-1:0]       pin_route_o,
  output logic [5:0]                 source_route_o
);

  // Reset release through two flops
  // Assert acts at once; only the release waits for two clock edges
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  // Internal reset copy used by every other register
  wire logic rst_n;
  assign rst_n = rst_sync2_reg;

  // State registers and their next values
  logic [15:0] greater_limit_value_reg;
  logic [15:0] greater_limit_value_next;
  logic [15:0] less_limit_value_reg;
  logic [15:0] less_limit_value_next;
  logic [15:0] result_word_reg;
  logic [15:0] result_word_next;
  logic [4:0]  input_select_reg;
  logic [4:0]  input_select_next;
  logic        window_hit_flag_reg;
  logic        window_hit_flag_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        hit;
  logic        sw_clear;
  // Compare terms, kept apart so each strict test reads on its own
  logic        above_greater;
  logic        below_less;
  logic        inside_mode;

  // Strict compares: a word equal to either limit is never a hit
  assign above_greater = (result_word_i > greater_limit_value_reg);
  assign below_less    = (result_word_i < less_limit_value_reg);
  // R4 ordering picks mode
  assign inside_mode   = (less_limit_value_reg > greater_limit_value_reg);

  // Window test on the incoming word, unchanged in its justification
  always_comb begin
    if (inside_mode) begin
      // R8 strictly inside
      hit = above_greater && below_less;
    end else begin
      // R9 strictly outside
      hit = below_less || above_greater;
    end
  end

  // Register writes and result capture. Limit bytes land one at a time,
  // so a result taken between two byte writes meets a half-new limit;
  // software should rewrite limits while no conversion is due.
  always_comb begin
    greater_limit_value_next = greater_limit_value_reg;
    less_limit_value_next    = less_limit_value_reg;
    result_word_next         = result_word_reg;
    input_select_next        = input_select_reg;
    sw_clear                 = flag_clear_i;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        // R5 greater limit bytes
        awc_pkg::ADDR_GT_LOW:  greater_limit_value_next[7:0]  = sfr_wdata_i;
        awc_pkg::ADDR_GT_HIGH: greater_limit_value_next[15:8] = sfr_wdata_i;
        // R6 less limit bytes
        awc_pkg::ADDR_LT_LOW:  less_limit_value_next[7:0]     = sfr_wdata_i;
        awc_pkg::ADDR_LT_HIGH: less_limit_value_next[15:8]    = sfr_wdata_i;
        // R13 channel select
        awc_pkg::ADDR_INPUT_SELECT: input_select_next = sfr_wdata_i[4:0];
        awc_pkg::ADDR_STATUS: begin
          // A one written here leaves the flag, so read-modify-write is safe
          if (!sfr_wdata_i[awc_pkg::FLAG_BIT]) begin
            sw_clear = 1'b1;  // Writing zero clears the flag
          end
        end
        default: begin
        end
      endcase
    end
    // R10 R11 word kept as delivered, 10-bit data in either justification
    if (result_valid_i) begin
      result_word_next = result_word_i;
    end
  end

  // Flag update; a hit and a clear in one cycle leave the flag set,
  // because the hit is the newer event and must not be lost
  always_comb begin
    // R16 set beats clear
    if (result_valid_i && hit) begin
      window_hit_flag_next = 1'b1;
    end else if (sw_clear) begin
      window_hit_flag_next = 1'b0;
    end else begin
      window_hit_flag_next = window_hit_flag_reg;
    end
  end

  // Read data, registered so it is valid the cycle after the strobe
  // Unmapped reads give zero instead of stale data
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        awc_pkg::ADDR_GT_LOW:       rdata_next = greater_limit_value_reg[7:0];
        awc_pkg::ADDR_GT_HIGH:      rdata_next = greater_limit_value_reg[15:8];
        awc_pkg::ADDR_LT_LOW:       rdata_next = less_limit_value_reg[7:0];
        awc_pkg::ADDR_LT_HIGH:      rdata_next = less_limit_value_reg[15:8];
        awc_pkg::ADDR_INPUT_SELECT: rdata_next = {3'h0, input_select_reg};
        // Last word taken, read-only; writes to it are ignored
        awc_pkg::ADDR_RESULT_LOW:   rdata_next = result_word_reg[7:0];
        awc_pkg::ADDR_RESULT_HIGH:  rdata_next = result_word_reg[15:8];
        // R2 polled status
        awc_pkg::ADDR_STATUS:       rdata_next = {7'h00, window_hit_flag_reg};
        default:                    rdata_next = 8'h00;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      // Reset limits form an outside window no word can reach: no hit
      // R3 limits only from these pairs
      greater_limit_value_reg <= awc_pkg::GT_RESET;
      less_limit_value_reg    <= awc_pkg::LT_RESET;
      result_word_reg         <= 16'h0000;
      input_select_reg        <= awc_pkg::SELECT_RESET;
      window_hit_flag_reg     <= 1'b0;
      rdata_reg               <= 8'h00;
    end else begin
      greater_limit_value_reg <= greater_limit_value_next;
      less_limit_value_reg    <= less_limit_value_next;
      result_word_reg         <= result_word_next;
      input_select_reg        <= input_select_next;
      // R1 continuous comparison
      window_hit_flag_reg     <= window_hit_flag_next;
      rdata_reg               <= rdata_next;
    end
  end

  // Source routing from the selector; reserved codes route nothing
  always_comb begin
    source_route_o = 6'h00;
    // R12 one positive source
    case (input_select_reg)
      // Internal sources each own one fixed code
      awc_pkg::CH_TEMP:        source_route_o = awc_pkg::AWC_SRC_TEMP;
      awc_pkg::CH_BATTERY:     source_route_o = awc_pkg::AWC_SRC_BATTERY;
      awc_pkg::CH_CORE_SUPPLY: source_route_o = awc_pkg::AWC_SRC_CORE;
      awc_pkg::CH_MAIN_SUPPLY: source_route_o = awc_pkg::AWC_SRC_MAIN;
      awc_pkg::CH_GROUND:      source_route_o = awc_pkg::AWC_SRC_GROUND;
      default: begin
        if (input_select_reg <= awc_pkg::CH_LAST_PIN &&
            int'(input_select_reg) < PIN_COUNT) begin
          source_route_o = awc_pkg::AWC_SRC_PIN;
        end
      end
    endcase
  end

  // One decoder per pin; codes past the last pin code never route a pin,
  // so a larger pin count cannot alias the internal sources
  generate
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin_route
      // R12 one pin per code
      if (g <= int'(awc_pkg::CH_LAST_PIN)) begin : g_live
        assign pin_route_o[g] = (input_select_reg == 5'(g));
      end else begin : g_dead
        assign pin_route_o[g] = 1'b0;
      end
    end
  endgenerate

  // Interrupt level falls only when the flag is cleared
  // R2 flag also serves as interrupt level
  assign window_hit_flag_o = window_hit_flag_reg;
  assign window_irq_o      = window_hit_flag_reg;
  assign input_select_o    = input_select_reg;
  assign sfr_rdata_o       = rdata_reg;

endmodule : awc_window_compare

// ---- verification/awc_cpu_model.sv ----
// Processor-side model driving the special-function register strobes
`timescale 1ns/1ps
module awc_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // Released lines show inverted values so stale data never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // Data stands from the read edge on; take it at the following edge
    @(posedge clk_i);
    v = rdata_i;
  endtask : rd
endmodule : awc_cpu_model

// ---- verification/awc_window_compare_asserts.sv ----
// Port checker for the converter window comparator
`timescale 1ns/1ps
module awc_window_compare_asserts #(
  parameter int PIN_COUNT = 23
) (
  input wire logic                 clk_sys_i,
  input wire logic                 nrst_i,
  input wire logic [7:0]           sfr_addr_i,
  input wire logic                 sfr_wr_i,
  input wire logic                 sfr_rd_i,
  input wire logic [7:0]           sfr_wdata_i,
  input wire logic [7:0]           sfr_rdata_o,
  input wire logic                 result_valid_i,
  input wire logic [15:0]          result_word_i,
  input wire logic                 flag_clear_i,
  input wire logic                 window_hit_flag_o,
  input wire logic                 window_irq_o,
  input wire logic [4:0]           input_select_o,
  input wire logic [PIN_COUNT-1:0] pin_route_o,
  input wire logic [5:0]           source_route_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Software clear is a zero written to bit 0 of status
  wire stat_wr0 = sfr_wr_i && sfr_addr_i == 8'hc7 && !sfr_wdata_i[0];
  sequence stat_rd; sfr_rd_i && sfr_addr_i == 8'hc7; endsequence
  sequence clear_req; (flag_clear_i || stat_wr0) && !result_valid_i;
  endsequence
  a_irq_tracks_flag: assert property (
    window_irq_o == window_hit_flag_o) else $error("irq differs from flag");
  a_status_bit: assert property (
    stat_rd |=> sfr_rdata_o[0] == $past(window_hit_flag_o))
    else $error("status bit differs from flag");
  a_clear_drops: assert property (clear_req |=> !window_hit_flag_o)
    else $error("flag not cleared");
  a_flag_sticky: assert property (
    window_hit_flag_o && !flag_clear_i && !stat_wr0 |=> window_hit_flag_o)
    else $error("flag dropped without clear");
  a_no_spont_set: assert property (
    !result_valid_i && !window_hit_flag_o |=> !window_hit_flag_o)
    else $error("flag set without result");
  a_select_write: assert property (
    sfr_wr_i && sfr_addr_i == 8'hbb |=>
    input_select_o == $past(sfr_wdata_i[4:0])) else $error("select wrong");
  a_ground_route: assert property (
    input_select_o == 5'h1f |-> source_route_o == 6'h20)
    else $error("ground not routed");
  a_pin_route: assert property (
    input_select_o <= 5'h16 |-> source_route_o == 6'h01 &&
    pin_route_o == (PIN_COUNT'(1) << input_select_o)) else $error("pin route");
  a_rdata_holds: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");
endmodule : awc_window_compare_asserts
bind awc_window_compare awc_window_compare_asserts #(
  .PIN_COUNT(PIN_COUNT)
) u_chk (
  .clk_sys_i        (clk_sys_i),
  .nrst_i           (nrst_i),
  .sfr_addr_i       (sfr_addr_i),
  .sfr_wr_i         (sfr_wr_i),
  .sfr_rd_i         (sfr_rd_i),
  .sfr_wdata_i      (sfr_wdata_i),
  .sfr_rdata_o      (sfr_rdata_o),
  .result_valid_i   (result_valid_i),
  .result_word_i    (result_word_i),
  .flag_clear_i     (flag_clear_i),
  .window_hit_flag_o(window_hit_flag_o),
  .window_irq_o     (window_irq_o),
  .input_select_o   (input_select_o),
  .pin_route_o      (pin_route_o),
  .source_route_o   (source_route_o)
);

// ---- verification/awc_window_compare_tb.sv ----
// Self-checking bench for the converter window comparator
`timescale 1ns/1ps
module awc_window_compare_tb;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, result_valid_i = 1'b0;
  logic flag_clear_i = 1'b0, sfr_wr_i, sfr_rd_i;
  logic window_hit_flag_o, window_irq_o;
  logic [15:0] result_word_i = 16'h0000;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v;
  logic [4:0] input_select_o;
  logic [22:0] pin_route_o;
  logic [5:0] source_route_o;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  logic [7:0] ra[7] = '{8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hbb, 8'hc7, 8'h00};
  logic [7:0] rv[7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00};
  logic [15:0] iw[4] = '{16'h1000, 16'h1040, 16'h1fc0, 16'h2000};
  logic [15:0] ow[4] = '{16'h003f, 16'h0040, 16'h0080, 16'h0081};
  always #4 clk_sys_i = ~clk_sys_i;
  awc_window_compare #(
    .PIN_COUNT(23)
  ) dut (
    .clk_sys_i        (clk_sys_i),
    .nrst_i           (nrst_i),
    .sfr_addr_i       (sfr_addr_i),
    .sfr_wr_i         (sfr_wr_i),
    .sfr_rd_i         (sfr_rd_i),
    .sfr_wdata_i      (sfr_wdata_i),
    .sfr_rdata_o      (sfr_rdata_o),
    .result_valid_i   (result_valid_i),
    .result_word_i    (result_word_i),
    .flag_clear_i     (flag_clear_i),
    .window_hit_flag_o(window_hit_flag_o),
    .window_irq_o     (window_irq_o),
    .input_select_o   (input_select_o),
    .pin_route_o      (pin_route_o),
    .source_route_o   (source_route_o)
  );
  awc_cpu_model cpu (.clk_i(clk_sys_i), .rdata_i(sfr_rdata_o),
    .addr_o(sfr_addr_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i),
    .wdata_o(sfr_wdata_i));
  task automatic chk(string n, logic [22:0] e, logic [22:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    cpu.rd(a, v);
    chk("read data", 23'(e), 23'(v));
  endtask : rdc
  task automatic lim(logic [15:0] g, logic [15:0] l);
    cpu.wr(8'hc4, g[15:8]);
    cpu.wr(8'hc3, g[7:0]);
    cpu.wr(8'hc6, l[15:8]);
    cpu.wr(8'hc5, l[7:0]);
  endtask : lim
  // Present one result, then look at the flag once it has landed
  task automatic res(logic [15:0] w, logic e, logic clr);
    @(posedge clk_sys_i);
    result_valid_i <= 1'b1;
    result_word_i <= w;
    @(posedge clk_sys_i);
    result_valid_i <= 1'b0;
    result_word_i <= ~w;
    flag_clear_i <= clr;
    #1 chk("hit flag", 23'(e), 23'(window_hit_flag_o));
    chk("irq", 23'(e), 23'(window_irq_o));
    @(posedge clk_sys_i);
    flag_clear_i <= 1'b0;
  endtask : res
  function automatic logic [5:0] src(int c);
    if (c < 23) return 6'h01;
    if (c < 27) return 6'h00;
    return 6'h02 << (c - 27);
  endfunction : src
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Cut a hang short; the run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    lim(16'h1000, 16'h2000);
    rdc(8'hc4, 8'h10);
    rdc(8'hc6, 8'h20);
    foreach (iw[i]) res(iw[i], i == 1 || i == 2, 1'b1);
    lim(16'h0080, 16'h0040);
    foreach (ow[i]) res(ow[i], i == 0 || i == 3, 1'b1);
    res(16'h0000, 1'b1, 1'b0);
    res(16'h0060, 1'b1, 1'b0);
    rdc(8'hbd, 8'h60);
    cpu.wr(8'hc7, 8'h01);
    rdc(8'hc7, 8'h01);
    cpu.wr(8'hc7, 8'h00);
    rdc(8'hc7, 8'h00);
    // pin mode and skip bits are set by software outside the block
    for (int c = 0; c < 32; c++) begin
      cpu.wr(8'hbb, 8'(c) | 8'he0);
      #1 chk("select", 23'(c), 23'(input_select_o));
      chk("source", 23'(src(c)), 23'(source_route_o));
      chk("pins", c < 23 ? 23'(1) << c : 23'h0, pin_route_o);
    end
    // Mid-run reset with a set flag and a moved select: all back to reset
    cpu.wr(8'hbb, 8'h05);
    res(16'h0000, 1'b1, 1'b0);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("flag after reset", 23'h0, 23'(window_hit_flag_o));
    foreach (ra[i]) rdc(ra[i], rv[i]);
    complete_run();
  end
endmodule : awc_window_compare_tb
